// File: hdl/bmdma_pkg.sv
// Constants and types for the byte memory DMA engine.
// Assumes one 40 MHz clock and an APB master on the register side.
package bmdma_pkg;
   // Register byte addresses
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_IADDR  = 8'h04;
   localparam logic [7:0] A_EOFF   = 8'h08;
   localparam logic [7:0] A_EPAGE  = 8'h0c;
   localparam logic [7:0] A_WCNT   = 8'h10;
   localparam logic [7:0] A_SYSCTL = 8'h14;
   localparam logic [7:0] A_CMSEN  = 8'h18;
   localparam logic [7:0] A_STATUS = 8'h1c;
   // Control and system control field positions
   localparam int F_FMT  = 0;
   localparam int F_DIR  = 2;
   localparam int F_CRST = 3;
   localparam int F_OVL  = 4;
   localparam int F_WAIT = 8;
   localparam int F_BSDIS = 3;
   // Format codes
   localparam logic [1:0] FMT_PM24 = 2'h0;
   localparam logic [1:0] FMT_DM16 = 2'h1;
   localparam logic [1:0] FMT_DMHI = 2'h2;
   localparam logic [1:0] FMT_DMLO = 2'h3;
   // Reset and boot values
   localparam logic [3:0]  CMSEN_RST  = 4'hb;
   localparam logic [13:0] BOOT_WORDS = 14'h0020;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_MRD  = 3'b001,
      ST_MCAP = 3'b010,
      ST_BREQ = 3'b011,
      ST_BACC = 3'b100,
      ST_MWR  = 3'b101
   } bmdma_st_t;
endpackage : bmdma_pkg

// File: hdl/bmdma_top.sv
// Byte memory DMA engine with combined memory select and APB registers.
// Assumes core selects and core external requests are synchronous to clk_i.
`timescale 1ns/10ps
module bmdma_top (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        boot_byte_dma_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Core side
   input  wire logic        core_ext_req_i,
   input  wire logic        bus_granted_i,
   input  wire logic        program_memory_select_n_i,
   input  wire logic        data_memory_select_n_i,
   input  wire logic        io_space_select_n_i,
   output logic             core_hold_o,
   output logic             core_restart_o,
   output logic             byte_dma_done_o,
   // On-chip memory port
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic             mem_pm_o,
   output logic      [13:0] mem_addr_o,
   output logic      [3:0]  mem_overlay_select_o,
   output logic      [23:0] mem_wdata_o,
   input  wire logic [23:0] mem_rdata_i,
   // External byte bus
   output logic      [13:0] ext_addr_o,
   output logic      [23:0] ext_data_o,
   input  wire logic [23:0] ext_data_i,
   output logic             ext_page_oe_n_o,
   output logic             ext_byte_oe_n_o,
   output logic             ext_rd_n_o,
   output logic             ext_wr_n_o,
   output logic             byte_memory_select_n_o,
   output logic             combined_select_n_o
);

   typedef struct packed {
      bmdma_pkg::bmdma_st_t st;
      logic [1:0]  fmt;
      logic        dir;
      logic        crst;
      logic [3:0]  ovl;
      logic [2:0]  bwait;
      logic        bsdis;
      logic [3:0]  cmsen;
      logic [13:0] iaddr;
      logic [13:0] eoff;
      logic [7:0]  epage;
      logic [13:0] wcnt;
      logic [23:0] word;
      logic [7:0]  obyte;
      logic [1:0]  bidx;
      logic [2:0]  wsc;
      logic        bootchk;
      logic        bact;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        poe_n;
      logic        boe_n;
      logic        rd_n;
      logic        wr_n;
      logic        bms_n;
      logic        cms_n;
      logic        mreq;
      logic        mwe;
      logic        done;
      logic        hold;
      logic        restart;
      logic        pm;
   } bmdma_state_t;

   bmdma_state_t q_r;
   bmdma_state_t q_nxt;

   // Index of the last byte of a word for a format
   function automatic logic [1:0] last_byte(input logic [1:0] f);
      case (f)
         bmdma_pkg::FMT_PM24: last_byte = 2'h2;
         bmdma_pkg::FMT_DM16: last_byte = 2'h1;
         default:             last_byte = 2'h0;
      endcase
   endfunction : last_byte

   // Byte sent out, most significant first
   function automatic logic [7:0] pick(input logic [1:0] f, input logic [1:0] i,
                                       input logic [23:0] w);
      case (f)
         bmdma_pkg::FMT_PM24: pick = (i == 2'h0) ? w[23:16] : (i == 2'h1) ? w[15:8] : w[7:0];
         bmdma_pkg::FMT_DM16: pick = (i == 2'h0) ? w[15:8] : w[7:0];
         bmdma_pkg::FMT_DMHI: pick = w[15:8];
         default:             pick = w[7:0];
      endcase
   endfunction : pick

   logic        wr_acc;
   logic        rd_acc;
   logic [21:0] ext_next;
   logic [13:0] cnt_dec;

   always_comb begin
      q_nxt    = q_r;
      wr_acc   = psel_i && penable_i && q_r.pready && pwrite_i;
      rd_acc   = psel_i && penable_i && !q_r.pready;
      ext_next = {q_r.epage, q_r.eoff} + 22'h000001;
      cnt_dec  = q_r.wcnt - 14'h0001;
      q_nxt.done    = 1'b0;
      q_nxt.restart = 1'b0;
      q_nxt.bootchk = 1'b0;
      // APB: one wait cycle so answers come from flops
      q_nxt.pready  = rd_acc;
      q_nxt.pslverr = 1'b0;
      q_nxt.prdata  = 32'h0000_0000;
      if (rd_acc) begin
         case (paddr_i)
            bmdma_pkg::A_CTRL:   q_nxt.prdata = {21'h0, q_r.bwait, q_r.ovl, q_r.crst, q_r.dir, q_r.fmt};
            bmdma_pkg::A_IADDR:  q_nxt.prdata = {18'h0, q_r.iaddr};
            bmdma_pkg::A_EOFF:   q_nxt.prdata = {18'h0, q_r.eoff};
            bmdma_pkg::A_EPAGE:  q_nxt.prdata = {24'h0, q_r.epage};
            bmdma_pkg::A_WCNT:   q_nxt.prdata = {18'h0, q_r.wcnt};
            bmdma_pkg::A_SYSCTL: q_nxt.prdata = {28'h0, q_r.bsdis, 3'h0};
            bmdma_pkg::A_CMSEN:  q_nxt.prdata = {28'h0, q_r.cmsen};
            bmdma_pkg::A_STATUS: q_nxt.prdata = {30'h0, q_r.hold, q_r.st != bmdma_pkg::ST_IDLE};
            // Writes to holes are dropped quietly, only reads report an error
            default:             q_nxt.pslverr = !pwrite_i;
         endcase
      end
      if (wr_acc) begin
         case (paddr_i)
            bmdma_pkg::A_CTRL: begin
               q_nxt.fmt   = pwdata_i[bmdma_pkg::F_FMT +: 2];
               q_nxt.dir   = pwdata_i[bmdma_pkg::F_DIR];
               q_nxt.crst  = pwdata_i[bmdma_pkg::F_CRST];
               q_nxt.ovl   = pwdata_i[bmdma_pkg::F_OVL +: 4];
               q_nxt.bwait = pwdata_i[bmdma_pkg::F_WAIT +: 3];
            end
            bmdma_pkg::A_IADDR:  q_nxt.iaddr = pwdata_i[13:0];
            bmdma_pkg::A_EOFF:   q_nxt.eoff  = pwdata_i[13:0];
            bmdma_pkg::A_EPAGE:  q_nxt.epage = pwdata_i[7:0];
            bmdma_pkg::A_SYSCTL: q_nxt.bsdis = pwdata_i[bmdma_pkg::F_BSDIS];
            bmdma_pkg::A_CMSEN:  q_nxt.cmsen = pwdata_i[3:0];
            bmdma_pkg::A_WCNT: begin
               if (q_r.st == bmdma_pkg::ST_IDLE && pwdata_i[13:0] != 14'h0000) begin
                  q_nxt.wcnt = pwdata_i[13:0];
                  q_nxt.bidx = 2'h0;
                  q_nxt.st   = q_r.dir ? bmdma_pkg::ST_MRD : bmdma_pkg::ST_BREQ;
               end
            end
            default: q_nxt.pslverr = 1'b0;
         endcase
      end
      if (q_r.bootchk && boot_byte_dma_i) begin
         q_nxt.wcnt = bmdma_pkg::BOOT_WORDS;
         q_nxt.crst = 1'b1;
         q_nxt.st   = bmdma_pkg::ST_BREQ;
      end
      case (q_r.st)
         bmdma_pkg::ST_IDLE: q_nxt.bidx = 2'h0;
         bmdma_pkg::ST_MRD:  q_nxt.st = bmdma_pkg::ST_MCAP;
         bmdma_pkg::ST_MCAP: begin
            q_nxt.word = mem_rdata_i;
            q_nxt.st   = bmdma_pkg::ST_BREQ;
         end
         bmdma_pkg::ST_BREQ: begin
            if (!core_ext_req_i && !bus_granted_i) begin
               q_nxt.bact  = 1'b1;
               q_nxt.obyte = pick(q_r.fmt, q_r.bidx, q_r.word);
               q_nxt.wsc   = q_r.bwait;
               q_nxt.st    = bmdma_pkg::ST_BACC;
            end
         end
         bmdma_pkg::ST_BACC: begin
            if (q_r.wsc != 3'h0) begin
               q_nxt.wsc = q_r.wsc - 3'h1;
            end else begin
               q_nxt.bact = 1'b0;
               {q_nxt.epage, q_nxt.eoff} = ext_next;
               if (!q_r.dir) begin
                  q_nxt.word = {q_r.word[15:0], ext_data_i[15:8]};
               end
               q_nxt.bidx = q_r.bidx + 2'h1;
               q_nxt.st   = bmdma_pkg::ST_BREQ;
               if (q_r.bidx == last_byte(q_r.fmt)) begin
                  q_nxt.bidx = 2'h0;
                  if (!q_r.dir) begin
                     case (q_r.fmt)
                        bmdma_pkg::FMT_PM24: q_nxt.word = {q_r.word[15:0], ext_data_i[15:8]};
                        bmdma_pkg::FMT_DM16: q_nxt.word = {8'h00, q_r.word[7:0], ext_data_i[15:8]};
                        bmdma_pkg::FMT_DMHI: q_nxt.word = {8'h00, ext_data_i[15:8], 8'h00};
                        default:             q_nxt.word = {16'h0000, ext_data_i[15:8]};
                     endcase
                     q_nxt.st = bmdma_pkg::ST_MWR;
                  end else begin
                     q_nxt.wcnt  = cnt_dec;
                     q_nxt.iaddr = q_r.iaddr + 14'h0001;
                     q_nxt.st    = (cnt_dec == 14'h0000) ? bmdma_pkg::ST_IDLE : bmdma_pkg::ST_MRD;
                  end
               end
            end
         end
         bmdma_pkg::ST_MWR: begin
            q_nxt.wcnt  = cnt_dec;
            q_nxt.iaddr = q_r.iaddr + 14'h0001;
            q_nxt.st    = (cnt_dec == 14'h0000) ? bmdma_pkg::ST_IDLE : bmdma_pkg::ST_BREQ;
         end
         default: q_nxt.st = bmdma_pkg::ST_IDLE;
      endcase
      if (q_r.st != bmdma_pkg::ST_IDLE && q_nxt.st == bmdma_pkg::ST_IDLE) begin
         q_nxt.done    = 1'b1;
         q_nxt.restart = q_r.crst;
      end
      q_nxt.hold  = q_nxt.crst && q_nxt.st != bmdma_pkg::ST_IDLE;
      q_nxt.mreq  = q_nxt.st == bmdma_pkg::ST_MRD || q_nxt.st == bmdma_pkg::ST_MWR;
      q_nxt.mwe   = q_nxt.st == bmdma_pkg::ST_MWR;
      q_nxt.pm    = q_nxt.fmt == bmdma_pkg::FMT_PM24;
      q_nxt.rd_n  = !(q_nxt.bact && !q_r.dir);
      q_nxt.wr_n  = !(q_nxt.bact && q_r.dir);
      q_nxt.poe_n = !q_nxt.bact;
      q_nxt.boe_n = !(q_nxt.bact && q_r.dir);
      q_nxt.bms_n = !(q_nxt.bact && !q_nxt.bsdis) || bus_granted_i;
      q_nxt.cms_n = !((q_nxt.cmsen[0] && !program_memory_select_n_i) ||
                      (q_nxt.cmsen[1] && !data_memory_select_n_i) ||
                      (q_nxt.cmsen[2] && q_nxt.bact) ||
                      (q_nxt.cmsen[3] && !io_space_select_n_i)) || bus_granted_i;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q_r         <= '0;
         q_r.st      <= bmdma_pkg::ST_IDLE;
         q_r.cmsen   <= bmdma_pkg::CMSEN_RST;
         q_r.bootchk <= 1'b1;
         q_r.rd_n    <= 1'b1;
         q_r.wr_n    <= 1'b1;
         q_r.poe_n   <= 1'b1;
         q_r.boe_n   <= 1'b1;
         q_r.bms_n   <= 1'b1;
         q_r.cms_n   <= 1'b1;
         q_r.pm      <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata_o               = q_r.prdata;
   assign pready_o               = q_r.pready;
   assign pslverr_o              = q_r.pslverr;
   assign core_hold_o            = q_r.hold;
   assign core_restart_o         = q_r.restart;
   assign byte_dma_done_o        = q_r.done;
   assign mem_req_o              = q_r.mreq;
   assign mem_we_o               = q_r.mwe;
   assign mem_pm_o               = q_r.pm;
   assign mem_addr_o             = q_r.iaddr;
   assign mem_overlay_select_o   = q_r.ovl;
   assign mem_wdata_o            = q_r.word;
   assign ext_addr_o             = q_r.eoff;
   assign ext_data_o             = {q_r.epage, q_r.obyte, 8'h00};
   assign ext_page_oe_n_o        = q_r.poe_n;
   assign ext_byte_oe_n_o        = q_r.boe_n;
   assign ext_rd_n_o             = q_r.rd_n;
   assign ext_wr_n_o             = q_r.wr_n;
   assign byte_memory_select_n_o = q_r.bms_n;
   assign combined_select_n_o    = q_r.cms_n;

   // Checks
   logic [3:0] strb_len_r;
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || (ext_rd_n_o && ext_wr_n_o)) begin
         strb_len_r <= 4'h0;
      end else begin
         strb_len_r <= strb_len_r + 4'h1;
      end
   end

   chk_start_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_acc && paddr_i == bmdma_pkg::A_WCNT && pwdata_i[13:0] != 14'h0 && q_r.st == bmdma_pkg::ST_IDLE
      |=> q_r.st != bmdma_pkg::ST_IDLE) else $error("count write did not start engine");
   chk_wait_len: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(ext_rd_n_o && ext_wr_n_o) ##1 (ext_rd_n_o && ext_wr_n_o)
      |-> $past(strb_len_r) == {1'b0, q_r.bwait}) else $error("byte strobe length wrong");
   chk_steal_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mem_req_o |=> !mem_req_o) else $error("more than one stolen cycle");
   chk_fmt_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      mem_req_o && mem_we_o && q_r.fmt == bmdma_pkg::FMT_DMHI
      |-> mem_wdata_o[7:0] == 8'h00 && mem_wdata_o[23:16] == 8'h00) else $error("unused bits not zero");
   chk_done_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      byte_dma_done_o |-> q_r.wcnt == 14'h0 && q_r.st == bmdma_pkg::ST_IDLE) else $error("done with count left");
   chk_page_carry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(ext_rd_n_o && ext_wr_n_o) && $past(q_r.eoff) == 14'h3fff
      |-> q_r.eoff == 14'h0 && q_r.epage == 8'($past(q_r.epage) + 8'h01)) else $error("page carry lost");
   chk_core_first: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      core_ext_req_i && q_r.st == bmdma_pkg::ST_BREQ |=> ext_rd_n_o && ext_wr_n_o) else $error("byte access beat core");
   chk_bms_dis: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      q_r.bsdis && $past(q_r.bsdis) |-> byte_memory_select_n_o) else $error("byte select not suppressed");
   cov_boot_run: cover property (@(posedge clk_i) disable iff (!rst_n_i) byte_dma_done_o && core_restart_o);
   cov_write_out: cover property (@(posedge clk_i) disable iff (!rst_n_i) !ext_wr_n_o ##[1:8] byte_dma_done_o);
   cov_carry: cover property (@(posedge clk_i) disable iff (!rst_n_i) q_r.eoff == 14'h0 && $past(q_r.eoff) == 14'h3fff);

endmodule : bmdma_top

// File: tb/bmdma_bench.sv
// Self-checking bench for the byte memory DMA engine.
// Assumes the byte ROM model and the design top in the same run.
`timescale 1ns/10ps
module bmdma_bench;
   logic clk_i, rst_n_i, boot_byte_dma_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rs, ss, r;
   logic core_ext_req_i, bus_granted_i, pms_n, dms_n, ios_n, core_hold_o, core_restart_o, byte_dma_done_o;
   logic mem_req_o, mem_we_o, mem_pm_o, ext_page_oe_n_o, ext_byte_oe_n_o, ext_rd_n_o, ext_wr_n_o;
   logic [13:0] mem_addr_o, ext_addr_o, int_ptr;
   logic [3:0] ovl_o, cmsen, ovl;
   logic [23:0] mem_wdata_o, mem_rdata_i, ext_data_o, ext_data_i;
   logic bms_n_o, cms_n_o, slverr, dirv, crst, dis, str_d, req_d, grant_d, pms_d, dms_d, ios_d, bms_d, rst_d;
   logic [1:0] fmt;
   logic [2:0] waitv;
   logic [21:0] ext_ptr;
   logic [7:0] rq[$], wq[$];
   int words, dones, lowc, mismatches, checked;

   bmdma_top bmdma_top_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .boot_byte_dma_i(boot_byte_dma_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .core_ext_req_i(core_ext_req_i), .bus_granted_i(bus_granted_i),
      .program_memory_select_n_i(pms_n), .data_memory_select_n_i(dms_n), .io_space_select_n_i(ios_n),
      .core_hold_o(core_hold_o), .core_restart_o(core_restart_o), .byte_dma_done_o(byte_dma_done_o),
      .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_pm_o(mem_pm_o), .mem_addr_o(mem_addr_o),
      .mem_overlay_select_o(ovl_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
      .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_i(ext_data_i),
      .ext_page_oe_n_o(ext_page_oe_n_o), .ext_byte_oe_n_o(ext_byte_oe_n_o), .ext_rd_n_o(ext_rd_n_o),
      .ext_wr_n_o(ext_wr_n_o), .byte_memory_select_n_o(bms_n_o), .combined_select_n_o(cms_n_o));
   bmdma_bytemem bmdma_bytemem_i (.clk_i(clk_i), .addr_i(ext_addr_o), .data_i(ext_data_o),
      .rd_n_i(ext_rd_n_o), .data_o(ext_data_i));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [7:0] pat(input logic [21:0] p);
      return p[7:0] ^ p[21:14] ^ 8'h5a;
   endfunction : pat
   function automatic logic [23:0] mrd(input logic [13:0] a);
      return {a[7:0] ^ 8'h96, ~a[7:0], a[7:0] + 8'h03};
   endfunction : mrd
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic end_sim();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim
   // One APB transfer; only the watchdog bounds the wait for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i <= 1'b1; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      r = prdata_o;
      slverr = pslverr_o;
      psel_i <= 1'b0; penable_i <= 1'b0;
   endtask : apb
   task automatic wait_done(input int d0);
      int n;
      n = 0;
      while (dones == d0 && n < 3000) begin @(posedge clk_i); n++; end
      chk("done", dones != d0, 1);
   endtask : wait_done
   task automatic run(input logic [1:0] fm, input logic dr, input logic cr, input logic ds);
      logic [13:0] cnt;
      logic [3:0]  ce;
      rs = lfsr(rs);
      fmt = fm; dirv = dr; crst = cr; dis = ds; waitv = {1'b0, rs[1:0]}; ovl = rs[5:2];
      ce = {rs[6], ds | rs[7], rs[9:8]}; cnt = 14'(rs[11:10]) + 14'h1;
      ext_ptr = {rs[19:12], 12'hfff, rs[21:20]}; int_ptr = rs[29:16]; words = 0;
      apb(1, bmdma_pkg::A_CTRL, {21'h0, waitv, ovl, cr, dr, fm});
      apb(1, bmdma_pkg::A_IADDR, 32'(int_ptr));
      // page and offset only set while idle
      apb(1, bmdma_pkg::A_EOFF, 32'(ext_ptr[13:0]));
      apb(1, bmdma_pkg::A_EPAGE, 32'(ext_ptr[21:14]));
      apb(1, bmdma_pkg::A_SYSCTL, 32'(ds) << bmdma_pkg::F_BSDIS);
      apb(1, bmdma_pkg::A_CMSEN, 32'(ce));
      // Monitor follows the enables from the edge after the write lands
      cmsen <= ce;
      apb(1, bmdma_pkg::A_WCNT, 32'(cnt));
      wait_done(dones);
      apb(0, bmdma_pkg::A_WCNT, 32'h0);
      chk("wcnt", r, 32'h0);
      chk("words", words, 32'(cnt));
      chk("left", rq.size() + wq.size(), 0);
   endtask : run

   initial begin clk_i = 1'b0; forever #12.5 clk_i = ~clk_i; end
   initial begin repeat (60000) @(posedge clk_i); mismatches++; end_sim(); end
   // Core side traffic, random but repeatable
   always @(posedge clk_i) begin
      ss = lfsr(ss);
      core_ext_req_i <= ss[2:0] == 3'h0;
      bus_granted_i <= ss[6:3] == 4'h0;
      {pms_n, dms_n, ios_n} <= ss[9:7];
      mem_rdata_i <= mrd(mem_addr_o);
   end
   always @(posedge clk_i) begin : mon
      logic str;
      logic [23:0] e, w;
      str = !ext_rd_n_o || !ext_wr_n_o;
      if (rst_n_i && rst_d && str && !str_d) begin
         chk("take", req_d, 0);
         chk("addr", {ext_data_o[23:16], ext_addr_o}, ext_ptr);
         chk("poe", ext_page_oe_n_o, 0);
         chk("bms", bms_n_o, dis);
         chk("cmsb", cms_n_o, !((cmsen[0] & !pms_d) | (cmsen[1] & !dms_d) | cmsen[2] |
            (cmsen[3] & !ios_d)));
         chk("hold", core_hold_o, crst);
         chk("dir", ext_wr_n_o, !dirv);
         if (!ext_wr_n_o) begin
            chk("boe", ext_byte_oe_n_o, 0);
            chk("wbyte", ext_data_o[15:8], wq.pop_front());
         end else begin
            chk("boe", ext_byte_oe_n_o, 1);
            rq.push_back(pat(ext_ptr));
         end
         ext_ptr++;
      end
      if (str) lowc++;
      else if (str_d) begin chk("width", lowc, waitv + 1); lowc = 0; end
      else if (rst_n_i && rst_d && bms_n_o && bms_d)
         chk("cms", cms_n_o, grant_d | !((cmsen[0] & !pms_d) | (cmsen[1] & !dms_d) |
            (cmsen[3] & !ios_d)));
      if (mem_req_o === 1'b1) begin
         chk("iaddr", mem_addr_o, int_ptr);
         chk("pm", mem_pm_o, fmt == 2'h0);
         chk("ovl", ovl_o, ovl);
         chk("we", mem_we_o, !dirv);
         words++; int_ptr++;
         if (mem_we_o) begin
            e = 24'h0;
            for (int k = 0; k < (fmt == 0 ? 3 : fmt == 1 ? 2 : 1); k++) e = {e[15:0], rq.pop_front()};
            chk("word", mem_wdata_o, fmt == 2'h2 ? e << 8 : e);
         end else begin
            w = fmt == 2'h2 ? mrd(mem_addr_o) >> 8 : mrd(mem_addr_o);
            for (int k = (fmt == 0 ? 2 : fmt == 1 ? 1 : 0); k >= 0; k--) wq.push_back(w[8*k +: 8]);
         end
      end
      if (byte_dma_done_o === 1'b1) begin dones++; chk("rstrt", core_restart_o, crst); end
      str_d = str; req_d = core_ext_req_i | bus_granted_i; grant_d = bus_granted_i; bms_d = bms_n_o;
      {pms_d, dms_d, ios_d} = {pms_n, dms_n, ios_n}; rst_d = rst_n_i;
   end

   initial begin
      rs = 32'h75df41cd; ss = 32'h75df41cd; r = 32'h0;
      {rst_n_i, psel_i, penable_i, pwrite_i, core_ext_req_i, bus_granted_i} = 6'h0;
      {pms_n, dms_n, ios_n, boot_byte_dma_i} = 4'hf; paddr_i = 8'h0; pwdata_i = 32'h0; mem_rdata_i = 24'h0;
      {fmt, dirv, crst, dis, waitv, ovl, cmsen} = {2'h0, 1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 4'hb};
      {ext_ptr, int_ptr, str_d, rst_d, lowc} = '0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      wait_done(0);
      boot_byte_dma_i <= 1'b0;
      chk("boot", words, 32);
      apb(0, bmdma_pkg::A_CMSEN, 32'h0);
      chk("cmsen", r, 32'hb);
      apb(0, 8'h20, 32'h0);
      chk("slverr", slverr, 1);
      apb(1, bmdma_pkg::A_WCNT, 32'h0);
      apb(0, bmdma_pkg::A_STATUS, 32'h0);
      chk("zero", r[0], 0);
      for (int i = 0; i < 8; i++) run(i[1:0], i[2], i == 5, i == 6);
      end_sim();
   end
endmodule : bmdma_bench

// File: tb/bmdma_bytemem.sv
// Byte-wide external ROM model on the far side of the byte bus.
// Assumes page on data 23:16 and offset on the address lines.
`timescale 1ns/10ps
module bmdma_bytemem (
   // Clock
   input  wire logic        clk_i,
   // Byte bus
   input  wire logic [13:0] addr_i,
   input  wire logic [23:0] data_i,
   input  wire logic        rd_n_i,
   output logic      [23:0] data_o
);
   logic [7:0] idle_r = 8'ha5;
   logic [7:0] pat;
   // page and offset form the byte address
   assign pat = addr_i[7:0] ^ data_i[23:16] ^ 8'h5a;
   // Released bus keeps changing so a late sample cannot look right
   always_ff @(posedge clk_i) idle_r <= ~idle_r + 8'h01;
   // only lines 15:8 carry the byte
   assign data_o = !rd_n_i ? {~pat, pat, ~pat} : {3{idle_r}};
endmodule : bmdma_bytemem
